// ### design/port_clock_gating.v
// Clock gating control for eight general-purpose port units, with register port and fault check.
// Functional notes
// - A port whose active enable bit is one gets a clock; otherwise it stays unclocked.
// - Bus access to a port whose clock is gated off returns a bus fault.
// - Reset clears all run and sleep enable bits, leaving every port unclocked.
// - In run state the enables come from the run register at 0x108.
// - Sleep uses the sleep register at 0x118; deep sleep uses its own register.
// - Sleep and deep-sleep registers apply only when automatic gating is selected.
// - Bit 0 enables port A, up to bit 7 for port H.
// - Bits 8 to 31 read zero and ignore writes.
`include "port_clock_defines.vh"
module port_clock_gating #(
   parameter PORTS = `PORT_COUNT
) (
   input  wire             sys_clk_i,
   input  wire             rst_b_i,
   input  wire [11:0]      reg_addr_i,
   input  wire [31:0]      reg_wdata_i,
   input  wire             reg_write_i,
   input  wire             reg_read_i,
   output reg  [31:0]      reg_rdata_o,
   input  wire [1:0]       power_state_i,
   input  wire             port_access_i,
   input  wire [2:0]       port_select_i,
   output reg              bus_fault_o,
   output wire [PORTS-1:0] port_enable_o,
   output wire [PORTS-1:0] port_clk_o,
   output wire             irq_o
);
   reg  [PORTS-1:0]      run_en_reg;
   reg  [PORTS-1:0]      sleep_en_reg;
   reg  [PORTS-1:0]      deep_en_reg;
   reg                   acg_reg;
   reg  [`IRQ_WIDTH-1:0] irq_status_reg;
   reg  [`IRQ_WIDTH-1:0] irq_mask_reg;
   reg  [2:0]            fault_port_reg;
   reg  [PORTS-1:0]      active_prev_reg;
   reg  [31:0]           rdata_next;
   wire [PORTS-1:0]      active_en;
   wire                  fault_now;
   wire                  change_now;
   wire [`IRQ_WIDTH-1:0] irq_events;
   wire [`IRQ_WIDTH-1:0] irq_clear;

   function hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   enable_select #(
      .PORTS(PORTS)
   ) u_select (
      .power_state_i (power_state_i),
      .auto_gating_i (acg_reg),
      .run_en_i      (run_en_reg),
      .sleep_en_i    (sleep_en_reg),
      .deep_en_i     (deep_en_reg),
      .active_en_o   (active_en)
   );

   genvar g;
   generate
      for (g = 0; g < PORTS; g = g + 1) begin : gen_gate
         glitch_free_clock_gate u_gate (
            .clk_i       (sys_clk_i),
            .rst_b_i     (rst_b_i),
            .enable_i    (active_en[g]),
            .gated_clk_o (port_clk_o[g])
         );
      end
   endgenerate

   assign port_enable_o = active_en;

   // A fault is signalled combinationally beside the access so the bus can end it at once.
   assign fault_now = port_access_i & ~active_en[port_select_i];
   always @* begin
      bus_fault_o = fault_now;
   end

   assign change_now = (active_prev_reg != active_en);
   assign irq_events = {change_now, fault_now};
   assign irq_clear  = (reg_write_i && hit(reg_addr_i, `IRQ_STATUS_OFS)) ?
                       reg_wdata_i[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_en_reg      <= `ENABLE_RESET;
         sleep_en_reg    <= `ENABLE_RESET;
         deep_en_reg     <= `ENABLE_RESET;
         acg_reg         <= 1'b0;
         irq_mask_reg    <= {`IRQ_WIDTH{1'b0}};
         irq_status_reg  <= {`IRQ_WIDTH{1'b0}};
         fault_port_reg  <= 3'h0;
         active_prev_reg <= `ENABLE_RESET;
      end else begin
         active_prev_reg <= active_en;
         // Set wins over a clear in the same cycle so no event is lost.
         irq_status_reg  <= (irq_status_reg & ~irq_clear) | irq_events;
         if (fault_now) begin
            fault_port_reg <= port_select_i;
         end
         if (reg_write_i) begin
            if (hit(reg_addr_i, `RUN_PORT_CLOCK_ENABLES_OFS)) begin
               run_en_reg <= reg_wdata_i[PORTS-1:0];
            end
            if (hit(reg_addr_i, `SLEEP_PORT_CLOCK_ENABLES_OFS)) begin
               sleep_en_reg <= reg_wdata_i[PORTS-1:0];
            end
            if (hit(reg_addr_i, `DEEPSLEEP_PORT_CLOCK_ENABLES_OFS)) begin
               deep_en_reg <= reg_wdata_i[PORTS-1:0];
            end
            if (hit(reg_addr_i, `RUN_CLOCK_CONFIGURATION_OFS)) begin
               acg_reg <= reg_wdata_i[`ACG_BIT];
            end
            if (hit(reg_addr_i, `IRQ_MASK_OFS)) begin
               irq_mask_reg <= reg_wdata_i[`IRQ_WIDTH-1:0];
            end
         end
      end
   end

   always @* begin
      rdata_next = 32'h0000_0000;
      if (reg_read_i) begin
         if (hit(reg_addr_i, `RUN_PORT_CLOCK_ENABLES_OFS)) begin
            rdata_next[PORTS-1:0] = run_en_reg;
         end else if (hit(reg_addr_i, `SLEEP_PORT_CLOCK_ENABLES_OFS)) begin
            rdata_next[PORTS-1:0] = sleep_en_reg;
         end else if (hit(reg_addr_i, `DEEPSLEEP_PORT_CLOCK_ENABLES_OFS)) begin
            rdata_next[PORTS-1:0] = deep_en_reg;
         end else if (hit(reg_addr_i, `RUN_CLOCK_CONFIGURATION_OFS)) begin
            rdata_next[`ACG_BIT] = acg_reg;
         end else if (hit(reg_addr_i, `IRQ_STATUS_OFS)) begin
            rdata_next[`IRQ_WIDTH-1:0] = irq_status_reg;
         end else if (hit(reg_addr_i, `IRQ_MASK_OFS)) begin
            rdata_next[`IRQ_WIDTH-1:0] = irq_mask_reg;
         end else if (hit(reg_addr_i, `ACCESS_FAULT_INFO_OFS)) begin
            rdata_next[2:0]         = fault_port_reg;
            rdata_next[PORTS+7:8]   = active_en;
         end
      end
   end

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else begin
         reg_rdata_o <= rdata_next;
      end
   end

   assign irq_o = |(irq_status_reg & irq_mask_reg);
endmodule // port_clock_gating

// ### common/port_clock_defines.vh
// Register offsets, field layout and power-state codes for the port clock gating block.
`ifndef PORT_CLOCK_DEFINES_VH
`define PORT_CLOCK_DEFINES_VH

`define RUN_PORT_CLOCK_ENABLES_OFS      12'h108
`define SLEEP_PORT_CLOCK_ENABLES_OFS    12'h118
`define DEEPSLEEP_PORT_CLOCK_ENABLES_OFS 12'h128
`define RUN_CLOCK_CONFIGURATION_OFS     12'h060
`define IRQ_STATUS_OFS                  12'h200
`define IRQ_MASK_OFS                    12'h204
`define ACCESS_FAULT_INFO_OFS           12'h208

`define ENABLE_RESET                    8'h00
`define ACG_BIT                         27
`define PORT_COUNT                      8

`define PWR_RUN                         2'h0
`define PWR_SLEEP                       2'h1
`define PWR_DEEPSLEEP                   2'h2

`define IRQ_BIT_FAULT                   0
`define IRQ_BIT_CHANGE                  1
`define IRQ_WIDTH                       2

`endif

// ### design/glitch_free_clock_gate.v
// Clock gate whose enable is retimed on the falling edge, so it only changes while the source clock is low.
module glitch_free_clock_gate (
   input  wire clk_i,
   input  wire rst_b_i,
   input  wire enable_i,
   output wire gated_clk_o
);
   reg enable_reg;

   // A falling-edge flop replaces the usual low-transparent latch: the enable is frozen through the
   // high phase just the same, and no process is left half combinational.
   always @(negedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enable_reg <= 1'b0;
      end else begin
         enable_reg <= enable_i;
      end
   end

   assign gated_clk_o = clk_i & enable_reg;
endmodule // glitch_free_clock_gate

// ### design/enable_select.v
// Chooses which set of port enables applies in the current power state.
`include "port_clock_defines.vh"
module enable_select #(
   parameter PORTS = `PORT_COUNT
) (
   input  wire [1:0]       power_state_i,
   input  wire             auto_gating_i,
   input  wire [PORTS-1:0] run_en_i,
   input  wire [PORTS-1:0] sleep_en_i,
   input  wire [PORTS-1:0] deep_en_i,
   output reg  [PORTS-1:0] active_en_o
);
   always @* begin
      active_en_o = run_en_i;
      if (auto_gating_i) begin
         case (power_state_i)
            `PWR_SLEEP:     active_en_o = sleep_en_i;
            `PWR_DEEPSLEEP: active_en_o = deep_en_i;
            default:        active_en_o = run_en_i;
         endcase
      end
   end
endmodule // enable_select

// ### testbench/port_clock_gating_properties.sv
// Checker for the port clock gating block.
module port_clock_gating_properties #(
   parameter PORTS = 8
) (
   input wire logic             sys_clk_i,
   input wire logic             rst_b_i,
   input wire logic             reg_write_i,
   input wire logic             reg_read_i,
   input wire logic             port_access_i,
   input wire logic             bus_fault_o,
   input wire logic [11:0]      reg_addr_i,
   input wire logic [31:0]      reg_wdata_i,
   input wire logic [31:0]      reg_rdata_o,
   input wire logic [1:0]       power_state_i,
   input wire logic [2:0]       port_select_i,
   input wire logic [PORTS-1:0] port_enable_o,
   input wire logic [PORTS-1:0] port_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_fault_when_off: assert property (port_access_i |-> bus_fault_o == !port_enable_o[port_select_i])
      else $error("bus fault disagrees with the enable");
   // Sampled just before the rising edge, so every gated clock must be in its low phase.
   a_clk_low_phase: assert property (port_clk_o == '0)
      else $error("gated clock high in low phase");
   a_clk_follows_en: assert property (@(negedge sys_clk_i) $stable(port_enable_o) |-> port_clk_o == port_enable_o)
      else $error("gated clock disagrees with enable");
   a_reset_clears: assert property ($rose(rst_b_i) |-> port_enable_o == '0)
      else $error("enables not clear after reset");
   a_run_write_applies: assert property (reg_write_i && reg_addr_i == 12'h108 && power_state_i == 2'h0 ##1
      power_state_i == 2'h0 |-> port_enable_o == $past(reg_wdata_i[7:0]))
      else $error("run write not applied");
   a_enables_hold: assert property (!reg_write_i ##1 $stable(power_state_i) |-> $stable(port_enable_o))
      else $error("enables changed without cause");
   a_reserved_zero: assert property (reg_read_i && (reg_addr_i == 12'h108 || reg_addr_i == 12'h118)
      |=> reg_rdata_o[31:8] == 24'h00_0000)
      else $error("reserved bits read nonzero");
   a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data outside its cycle");
endmodule // port_clock_gating_properties
bind port_clock_gating port_clock_gating_properties #(.PORTS(PORTS)) u_chk (.sys_clk_i, .rst_b_i, .reg_write_i,
   .reg_read_i, .port_access_i, .bus_fault_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .power_state_i,
   .port_select_i, .port_enable_o, .port_clk_o);

// ### testbench/port_unit_model.sv
// Port units that count the rising edges of their gated clocks.
module port_unit_model (
   input  wire logic       clr_i,
   input  wire logic [7:0] port_clk_i,
   output int              cnt_o [8]
);
   timeunit 1ns;
   timeprecision 1ps;
   for (genvar g = 0; g < 8; g++) begin : unit
      int c;
      // A unit only advances on its own gated clock, so a stopped clock freezes it.
      always @(posedge port_clk_i[g] or posedge clr_i) begin
         if (clr_i)
            c <= 0;
         else
            c <= c + 1;
      end
      assign cnt_o[g] = c;
   end
endmodule // port_unit_model

// ### testbench/gpio_port_clock_gating_bench.sv
// Self-checking bench for the port clock gating block.
`include "port_clock_defines.vh"
module gpio_port_clock_gating_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst_b = 0, we = 0, re = 0, acc = 0, clr = 0;
   logic [11:0] addr = 0;
   logic [31:0] wd = 0;
   logic [1:0]  ps = 0;
   logic [2:0]  sel = 0;
   wire  [31:0] rd;
   wire  [7:0]  en, pclk;
   wire         fault, irq;
   int          cnt [8];
   int          failures = 0, n_checks = 0;
   bit   [7:0]  run_m, slp_m, dp_m, e;
   bit          acg_m;
   logic [11:0] ofs [5] = '{12'h108, 12'h118, 12'h128, 12'h060, 12'h300};
   always #2.5 clk = ~clk;
   port_clock_gating dut (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_write_i(we),
      .reg_read_i(re), .reg_rdata_o(rd), .power_state_i(ps), .port_access_i(acc), .port_select_i(sel),
      .bus_fault_o(fault), .port_enable_o(en), .port_clk_o(pclk), .irq_o(irq));
   port_unit_model units (.clr_i(clr), .port_clk_i(pclk), .cnt_o(cnt));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function bit [7:0] act();
      if (acg_m && ps == `PWR_SLEEP) return slp_m;
      if (acg_m && ps == `PWR_DEEPSLEEP) return dp_m;
      return run_m;
   endfunction
   function bit [31:0] regv(input [11:0] a);
      case (a)
         12'h108: return run_m;
         12'h118: return slp_m;
         12'h128: return dp_m;
         12'h060: return {4'h0, acg_m, 27'h0};
         default: return 0;
      endcase
   endfunction
   task wr(input [11:0] a, input [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      we <= 1;
      @(posedge clk);
      we <= 0;
      case (a)
         12'h108: run_m = d[7:0];
         12'h118: slp_m = d[7:0];
         12'h128: dp_m = d[7:0];
         12'h060: acg_m = d[`ACG_BIT];
      endcase
      #1;
   endtask
   task rdc(input [11:0] a, input [31:0] x);
      @(posedge clk);
      addr <= a;
      re <= 1;
      @(posedge clk);
      re <= 0;
      #1 chk(rd, x);
   endtask
   task end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   initial begin
      logic [11:0] a;
      a = $urandom(32'h1884_edb5);
      repeat (2) @(posedge clk);
      rst_b <= 1;
      for (int i = 0; i < 3; i++) rdc(ofs[i], 0);
      chk(en, 0);
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         a = ofs[$urandom_range(4)];
         wr(a, $urandom);
         rdc(a, regv(a));
         @(posedge clk);
         ps <= $urandom_range(3);
         acc <= 1;
         sel <= $urandom;
         #1 e = act();
         chk(en, e);
         chk(fault, !e[sel]);
         @(posedge clk);
         acc <= 0;
      end
      $display("test select done");
      wr(12'h060, 0);
      wr(12'h108, 32'h0000_0005);
      @(posedge clk);
      ps <= `PWR_DEEPSLEEP;
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      repeat (10) @(posedge clk);
      #1 for (int i = 0; i < 3; i++) chk(cnt[i], i == 1 ? 0 : 10);
      $display("test clocks done");
      wr(12'h200, 32'h0000_0003);
      wr(12'h204, 32'h0000_0001);
      chk(irq, 0);
      @(posedge clk);
      acc <= 1;
      sel <= 1;
      @(posedge clk);
      acc <= 0;
      #1 chk(irq, 1);
      // Port B is off, so the fault records port 1 beside the active enables of ports A and C.
      rdc(12'h208, 32'h0000_0501);
      rdc(12'h200, 32'h0000_0001);
      wr(12'h204, 0);
      chk(irq, 0);
      wr(12'h204, 1);
      chk(irq, 1);
      wr(12'h200, 1);
      chk(irq, 0);
      // The change event lands one edge after the new enables appear.
      wr(12'h204, 32'h0000_0002);
      wr(12'h108, 32'h0000_0007);
      chk(irq, 0);
      @(posedge clk);
      #1 chk(irq, 1);
      $display("test interrupt done");
      end_of_test();
   end
endmodule // gpio_port_clock_gating_bench
